/* File: bdf_pkg.sv */
// constants, register map and types of the block ram / fifo block
// assumes one clock domain; every file except the output latch imports the whole package
package bdf_pkg;

	// -----------------------------------------------------------------
	// memory geometry
	// -----------------------------------------------------------------
	localparam int         BDF_ADDR_W   = 4;
	localparam int         BDF_DATA_W   = 8;
	localparam int         BDF_PTR_W    = 5;
	localparam int         BDF_RADDR_W  = 3;
	localparam int         BDF_RDATA_W  = 8;
	localparam logic [4:0] BDF_PTR_ONE  = 5'h01;
	localparam logic [4:0] BDF_FIFO_MAX = 5'h0F;
	localparam logic [4:0] BDF_THR_MIN  = 5'h01;
	localparam logic [4:0] BDF_THR_HIGH = 5'h0E;

	// -----------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------
	localparam logic [2:0] BDF_OFS_CTRL   = 3'h0;
	localparam logic [2:0] BDF_OFS_FULL   = 3'h1;
	localparam logic [2:0] BDF_OFS_AFULL  = 3'h2;
	localparam logic [2:0] BDF_OFS_AEMPTY = 3'h3;
	localparam logic [2:0] BDF_OFS_STATUS = 3'h4;
	localparam logic [2:0] BDF_OFS_COUNT  = 3'h5;

	// -----------------------------------------------------------------
	// field positions and reset values
	// -----------------------------------------------------------------
	localparam int         BDF_CTRL_FIFO_BIT    = 0;
	localparam int         BDF_CTRL_WM_LSB      = 1;
	localparam int         BDF_CTRL_A_ASYNC_BIT = 3;
	localparam int         BDF_CTRL_B_ASYNC_BIT = 4;
	localparam logic [7:0] BDF_CTRL_MASK        = 8'h1F;
	localparam int         BDF_ST_EMPTY_BIT     = 0;
	localparam int         BDF_ST_AEMPTY_BIT    = 1;
	localparam int         BDF_ST_AFULL_BIT     = 2;
	localparam int         BDF_ST_FULL_BIT      = 3;
	localparam logic [7:0] BDF_CTRL_RST         = 8'h00;
	localparam logic [4:0] BDF_FULL_RST         = 5'h0F;
	localparam logic [4:0] BDF_AFULL_RST        = 5'h0C;
	localparam logic [4:0] BDF_AEMPTY_RST       = 5'h02;

	typedef enum logic [1:0] {
		BDF_WM_NORMAL  = 2'h0,
		BDF_WM_THROUGH = 2'h1,
		BDF_WM_RBW     = 2'h2
	} bdf_wmode_t;

endpackage : bdf_pkg

/* File: bdf_mem.sv */
// memory carrier interface and the storage array with registered read ports
// assumes the controller never reads and writes through one port at odd widths
`timescale 1ns/1ps

interface bdf_mem_if;
	import bdf_pkg::*;
	logic                  we;
	logic [BDF_ADDR_W-1:0] waddr;
	logic [BDF_DATA_W-1:0] wdata;
	logic                  a_en;
	logic [BDF_ADDR_W-1:0] a_addr;
	logic [BDF_DATA_W-1:0] a_q;
	logic                  b_en;
	logic [BDF_ADDR_W-1:0] b_addr;
	logic [BDF_DATA_W-1:0] b_q;
	modport ctl (output we, waddr, wdata, a_en, a_addr, b_en, b_addr, input a_q, b_q);
	modport mem (input we, waddr, wdata, a_en, a_addr, b_en, b_addr, output a_q, b_q);
endinterface : bdf_mem_if

module bdf_mem
	import bdf_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	bdf_mem_if.mem   mp
);
	logic [BDF_DATA_W-1:0] store [0:(1<<BDF_ADDR_W)-1];
	logic [BDF_DATA_W-1:0] a_q_reg;
	logic [BDF_DATA_W-1:0] b_q_reg;

	// array has no reset: contents survive every reset by design
	always_ff @(posedge clk) begin
		if (mp.we) begin
			store[mp.waddr] <= mp.wdata;
		end
	end

	// read samples the old word, so a same-edge write is seen one access later
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			a_q_reg <= '0;
			b_q_reg <= '0;
		end else begin
			if (mp.a_en) a_q_reg <= store[mp.a_addr];
			if (mp.b_en) b_q_reg <= store[mp.b_addr];
		end
	end

	assign mp.a_q = a_q_reg;
	assign mp.b_q = b_q_reg;

endmodule : bdf_mem

/* File: bdf_out_latch.sv */
// one port output data latch with local, global and selectable async clear
// assumes arst_n already merges the block reset and the global reset
`timescale 1ns/1ps

module bdf_out_latch #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         local_rst,
	input  wire logic         async_sel,
	input  wire logic         load,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] q_reg;
	wire          clear_n = arst_n & ~(local_rst & async_sel);

	// gated async clear: async_sel must be static while local_rst toggles
	always_ff @(posedge clk or negedge clear_n) begin
		if (!clear_n) begin
			q_reg <= '0;
		end else if (local_rst) begin
			q_reg <= '0;
		end else if (load) begin
			q_reg <= d;
		end
	end

	assign q = q_reg;

endmodule : bdf_out_latch

/* File: bdf_top.sv */
// block ram usable as single/dual port ram or as a fifo with programmable flags
// assumes all inputs synchronous to clk; the two fifo port clocks are sampled levels
`timescale 1ns/1ps

module bdf_top
	import bdf_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   global_set_reset_n,
	input  wire logic [BDF_RADDR_W-1:0] reg_addr,
	input  wire logic [BDF_RDATA_W-1:0] reg_wdata,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	output logic      [BDF_RDATA_W-1:0] reg_rdata,
	input  wire logic [BDF_ADDR_W-1:0]  ram_a_addr,
	input  wire logic [BDF_DATA_W-1:0]  ram_a_wdata,
	input  wire logic                   ram_a_ce,
	input  wire logic                   ram_a_we,
	input  wire logic                   port_a_latch_reset,
	output logic      [BDF_DATA_W-1:0]  read_data_a,
	input  wire logic [BDF_ADDR_W-1:0]  ram_b_addr,
	input  wire logic                   ram_b_ce,
	input  wire logic                   port_b_latch_reset,
	output logic      [BDF_DATA_W-1:0]  read_data_b,
	input  wire logic [BDF_DATA_W-1:0]  fifo_wdata,
	input  wire logic                   write_clock_enable,
	input  wire logic                   write_enable,
	input  wire logic                   write_side_clock,
	input  wire logic                   read_clock_enable,
	input  wire logic                   read_strobe,
	input  wire logic                   read_side_clock,
	input  wire logic                   fifo_global_reset,
	input  wire logic                   read_pointer_reset,
	output logic                        full_flag,
	output logic                        almost_full_flag,
	output logic                        almost_empty_flag,
	output logic                        empty_flag
);

	// -----------------------------------------------------------------
	// registers and state
	// -----------------------------------------------------------------
	logic [7:0]                 ctrl_reg;
	logic [BDF_PTR_W-1:0]       full_thr_reg;
	logic [BDF_PTR_W-1:0]       afull_thr_reg;
	logic [BDF_PTR_W-1:0]       aempty_thr_reg;
	logic [BDF_RDATA_W-1:0]     reg_rdata_reg;
	logic [BDF_RDATA_W-1:0]     reg_rdata_next;
	logic [BDF_PTR_W-1:0]       wptr_reg;
	logic [BDF_PTR_W-1:0]       wptr_next;
	logic [BDF_PTR_W-1:0]       rptr_reg;
	logic [BDF_PTR_W-1:0]       rptr_next;
	logic                       wclk_prev_reg;
	logic                       rclk_prev_reg;
	logic                       full_flag_reg;
	logic                       afull_flag_reg;
	logic                       aempty_flag_reg;
	logic                       empty_flag_reg;
	logic                       a_acc_d_reg;
	logic                       a_wr_d_reg;
	logic [BDF_DATA_W-1:0]      a_wdata_d_reg;
	logic                       b_acc_d_reg;
	bdf_wmode_t                 wmode;

	bdf_mem_if mif ();

	// -----------------------------------------------------------------
	// configuration decode
	// -----------------------------------------------------------------
	wire                 fifo_mode = ctrl_reg[BDF_CTRL_FIFO_BIT];
	wire                 a_async   = ctrl_reg[BDF_CTRL_A_ASYNC_BIT];
	wire                 b_async   = ctrl_reg[BDF_CTRL_B_ASYNC_BIT];
	wire [1:0]           wm_field  = ctrl_reg[BDF_CTRL_WM_LSB+1:BDF_CTRL_WM_LSB];
	assign wmode = bdf_wmode_t'(wm_field);

	// threshold writes are clamped so the flags always have a legal reference
	wire [BDF_PTR_W-1:0] wd5       = reg_wdata[BDF_PTR_W-1:0];
	wire                 wd_over   = |reg_wdata[BDF_RDATA_W-1:BDF_PTR_W];
	wire                 wd_low    = ~wd_over & (wd5 < BDF_THR_MIN);
	wire [BDF_PTR_W-1:0] full_wval = wd_low ? BDF_THR_MIN :
	                                 (wd_over | (wd5 > BDF_FIFO_MAX)) ? BDF_FIFO_MAX : wd5;
	wire [BDF_PTR_W-1:0] part_wval = wd_low ? BDF_THR_MIN :
	                                 (wd_over | (wd5 > BDF_THR_HIGH)) ? BDF_THR_HIGH : wd5;
	wire [BDF_PTR_W-1:0] full_m1   = full_thr_reg - BDF_PTR_ONE;
	wire [BDF_PTR_W-1:0] afull_eff = (afull_thr_reg > full_m1) ? full_m1 : afull_thr_reg;
	wire [BDF_PTR_W-1:0] aempty_eff = (aempty_thr_reg > full_m1) ? full_m1 : aempty_thr_reg;

	wire wr_ctrl   = reg_write & (reg_addr == BDF_OFS_CTRL);
	wire wr_full   = reg_write & (reg_addr == BDF_OFS_FULL);
	wire wr_afull  = reg_write & (reg_addr == BDF_OFS_AFULL);
	wire wr_aempty = reg_write & (reg_addr == BDF_OFS_AEMPTY);

	// -----------------------------------------------------------------
	// fifo pointers and flags
	// -----------------------------------------------------------------
	// port clocks are sampled levels; a rising level is that port's edge
	wire wr_tick = write_side_clock & ~wclk_prev_reg;
	wire rd_tick = read_side_clock & ~rclk_prev_reg;
	wire wr_acc  = fifo_mode & wr_tick & write_clock_enable & write_enable
	               & ~full_flag_reg & ~fifo_global_reset;
	wire rd_acc  = fifo_mode & rd_tick & read_clock_enable & read_strobe
	               & ~empty_flag_reg & ~fifo_global_reset & ~read_pointer_reset;

	assign wptr_next = fifo_global_reset ? '0 :
	                   wr_acc ? wptr_reg + BDF_PTR_ONE : wptr_reg;
	assign rptr_next = (fifo_global_reset | read_pointer_reset) ? '0 :
	                   rd_acc ? rptr_reg + BDF_PTR_ONE : rptr_reg;

	// each side sees its own fresh pointer against the other's current one
	wire [BDF_PTR_W-1:0] cnt_now  = wptr_reg - rptr_reg;
	wire [BDF_PTR_W-1:0] cnt_wsd  = wptr_next - rptr_reg;
	wire [BDF_PTR_W-1:0] cnt_rsd  = wptr_reg - rptr_next;
	wire full_nx   = cnt_wsd >= full_thr_reg;
	wire afull_nx  = cnt_wsd >= afull_eff;
	wire empty_nx  = cnt_rsd == '0;
	wire aempty_nx = cnt_rsd <= aempty_eff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wclk_prev_reg <= 1'b0;
			rclk_prev_reg <= 1'b0;
			wptr_reg      <= '0;
			rptr_reg      <= '0;
		end else begin
			wclk_prev_reg <= write_side_clock;
			rclk_prev_reg <= read_side_clock;
			wptr_reg      <= wptr_next;
			rptr_reg      <= rptr_next;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			full_flag_reg  <= 1'b0;
			afull_flag_reg <= 1'b0;
		end else if (fifo_global_reset) begin
			full_flag_reg  <= 1'b0;
			afull_flag_reg <= 1'b0;
		end else if (wr_tick) begin
			full_flag_reg  <= full_nx;
			afull_flag_reg <= afull_nx;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			empty_flag_reg  <= 1'b1;
			aempty_flag_reg <= 1'b1;
		end else if (fifo_global_reset) begin
			empty_flag_reg  <= 1'b1;
			aempty_flag_reg <= 1'b1;
		end else if (rd_tick) begin
			empty_flag_reg  <= empty_nx;
			aempty_flag_reg <= aempty_nx;
		end
	end

	// -----------------------------------------------------------------
	// memory port steering
	// -----------------------------------------------------------------
	wire ram_a_wr = ~fifo_mode & ram_a_ce & ram_a_we;
	assign mif.we     = fifo_mode ? wr_acc : ram_a_wr;
	assign mif.waddr  = fifo_mode ? wptr_reg[BDF_ADDR_W-1:0] : ram_a_addr;
	assign mif.wdata  = fifo_mode ? fifo_wdata : ram_a_wdata;
	assign mif.a_en   = ~fifo_mode & ram_a_ce;
	assign mif.a_addr = ram_a_addr;
	assign mif.b_en   = fifo_mode ? rd_acc : ram_b_ce;
	assign mif.b_addr = fifo_mode ? rptr_reg[BDF_ADDR_W-1:0] : ram_b_addr;

	bdf_mem u_mem (
		.clk    (clk),
		.resetn (resetn),
		.mp     (mif)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			a_acc_d_reg   <= 1'b0;
			a_wr_d_reg    <= 1'b0;
			a_wdata_d_reg <= '0;
			b_acc_d_reg   <= 1'b0;
		end else begin
			a_acc_d_reg   <= mif.a_en;
			a_wr_d_reg    <= ram_a_wr;
			a_wdata_d_reg <= ram_a_wdata;
			b_acc_d_reg   <= mif.b_en;
		end
	end

	// -----------------------------------------------------------------
	// output latches
	// -----------------------------------------------------------------
	// the reserved mode code falls back to normal behaviour
	wire a_normal = (wmode != BDF_WM_THROUGH) & (wmode != BDF_WM_RBW);
	wire a_load   = a_acc_d_reg & ~fifo_mode & ~(a_wr_d_reg & a_normal);
	wire [BDF_DATA_W-1:0] a_din = (a_wr_d_reg & (wmode == BDF_WM_THROUGH)) ?
	                              a_wdata_d_reg : mif.a_q;
	wire latch_arst_n = resetn & global_set_reset_n;

	bdf_out_latch #(.W(BDF_DATA_W)) u_latch_a (
		.clk       (clk),
		.arst_n    (latch_arst_n),
		.local_rst (port_a_latch_reset),
		.async_sel (a_async),
		.load      (a_load),
		.d         (a_din),
		.q         (read_data_a)
	);

	bdf_out_latch #(.W(BDF_DATA_W)) u_latch_b (
		.clk       (clk),
		.arst_n    (latch_arst_n),
		.local_rst (port_b_latch_reset),
		.async_sel (b_async),
		.load      (b_acc_d_reg),
		.d         (mif.b_q),
		.q         (read_data_b)
	);

	// -----------------------------------------------------------------
	// register port
	// -----------------------------------------------------------------
	wire [7:0] status_word = {4'h0, full_flag_reg, afull_flag_reg, aempty_flag_reg, empty_flag_reg};

	always_comb begin
		reg_rdata_next = '0;
		if (reg_read) begin
			unique case (reg_addr)
				BDF_OFS_CTRL:   reg_rdata_next = ctrl_reg;
				BDF_OFS_FULL:   reg_rdata_next = {3'h0, full_thr_reg};
				BDF_OFS_AFULL:  reg_rdata_next = {3'h0, afull_thr_reg};
				BDF_OFS_AEMPTY: reg_rdata_next = {3'h0, aempty_thr_reg};
				BDF_OFS_STATUS: reg_rdata_next = status_word;
				BDF_OFS_COUNT:  reg_rdata_next = {3'h0, cnt_now};
				default:        reg_rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg       <= BDF_CTRL_RST;
			full_thr_reg   <= BDF_FULL_RST;
			afull_thr_reg  <= BDF_AFULL_RST;
			aempty_thr_reg <= BDF_AEMPTY_RST;
			reg_rdata_reg  <= '0;
		end else begin
			if (wr_ctrl) ctrl_reg <= reg_wdata & BDF_CTRL_MASK;
			if (wr_full) full_thr_reg <= full_wval;
			if (wr_afull) afull_thr_reg <= part_wval;
			if (wr_aempty) aempty_thr_reg <= part_wval;
			reg_rdata_reg <= reg_rdata_next;
		end
	end

	assign reg_rdata         = reg_rdata_reg;
	assign full_flag         = full_flag_reg;
	assign almost_full_flag  = afull_flag_reg;
	assign almost_empty_flag = aempty_flag_reg;
	assign empty_flag        = empty_flag_reg;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	wire ok_a = global_set_reset_n & ~port_a_latch_reset & ~reg_write & ~fifo_mode;

	AST_FULL_WRITE_IGNORED: assert property (
		fifo_mode && wr_tick && write_clock_enable && write_enable && full_flag_reg && !fifo_global_reset
		|=> $stable(wptr_reg))
		else $error("write while full moved the write pointer");

	AST_EMPTY_READ_IGNORED: assert property (
		fifo_mode && rd_tick && read_clock_enable && read_strobe && empty_flag_reg
		&& !fifo_global_reset && !read_pointer_reset
		|=> $stable(rptr_reg) && $stable(read_data_b))
		else $error("read while empty changed read side");

	AST_FULL_ON_WCLK: assert property (
		$changed(full_flag_reg) || $changed(afull_flag_reg)
		|-> $past(wr_tick) || $past(fifo_global_reset))
		else $error("write side flag moved without write clock");

	AST_EMPTY_ON_RCLK: assert property (
		$changed(empty_flag_reg) || $changed(aempty_flag_reg)
		|-> $past(rd_tick) || $past(fifo_global_reset))
		else $error("read side flag moved without read clock");

	AST_FULL_VALUE: assert property (
		wr_tick && !rd_acc && !fifo_global_reset && !read_pointer_reset && !reg_write
		|=> full_flag_reg == ((wptr_reg - rptr_reg) >= full_thr_reg))
		else $error("full flag disagrees with word count");

	AST_EMPTY_VALUE: assert property (
		rd_tick && !wr_acc && !fifo_global_reset
		|=> empty_flag_reg == (wptr_reg == rptr_reg))
		else $error("empty flag disagrees with word count");

	AST_THR_RANGE: assert property (
		full_thr_reg >= BDF_THR_MIN && full_thr_reg <= BDF_FIFO_MAX
		&& afull_eff < full_thr_reg && aempty_eff < full_thr_reg)
		else $error("threshold outside programmable range");

	AST_FIFO_RESET: assert property (
		fifo_global_reset |=> wptr_reg == '0 && rptr_reg == '0 && empty_flag_reg
		&& aempty_flag_reg && !full_flag_reg && !afull_flag_reg)
		else $error("fifo reset left pointers or flags set");

	AST_RPTR_RESET: assert property (
		read_pointer_reset && !fifo_global_reset && !wr_acc
		|=> rptr_reg == '0 && $stable(wptr_reg))
		else $error("read pointer reset disturbed pointers");

	AST_NORMAL_WRITE: assert property (
		(ram_a_wr && a_normal && ok_a) ##1 ok_a ##1 ok_a |-> $stable(read_data_a))
		else $error("normal write changed port a output");

	AST_WRITE_THROUGH: assert property (
		(ram_a_wr && wmode == BDF_WM_THROUGH && ok_a) ##1 ok_a ##1 ok_a
		|-> read_data_a == $past(ram_a_wdata, 2))
		else $error("write-through data missing on port a");

	AST_READ_BEFORE: assert property (
		(ram_a_wr && wmode == BDF_WM_RBW && ok_a) ##1 ok_a ##1 ok_a
		|-> read_data_a == $past(mif.a_q))
		else $error("old word missing on port a");

	AST_LOCAL_RESET: assert property (
		port_a_latch_reset && global_set_reset_n && !port_b_latch_reset && !b_acc_d_reg
		|=> read_data_a == '0 && $stable(read_data_b))
		else $error("port a reset misbehaved");

	AST_GLOBAL_RESET: assert property (
		!global_set_reset_n |=> read_data_a == '0 && read_data_b == '0)
		else $error("global reset left latch data");

	COV_FIFO_FULL:  cover property (wr_acc ##1 full_flag_reg);
	COV_RETRANSMIT: cover property (read_pointer_reset && cnt_now != '0 ##1 rd_tick);
	COV_THROUGH:    cover property (ram_a_wr && wmode == BDF_WM_THROUGH);
	COV_RBW:        cover property (ram_a_wr && wmode == BDF_WM_RBW);

endmodule : bdf_top

/* File: bdf_fabric_model.sv */
// user fabric model driving the fifo write and read ports of the block
// assumes the bench calls push and pop; port clocks idle low between edges
`timescale 1ns/1ps

module bdf_fabric_model
	import bdf_pkg::*;
(
	input  wire logic                  clk,
	output logic      [BDF_DATA_W-1:0] fifo_wdata,
	output logic                       write_clock_enable,
	output logic                       write_enable,
	output logic                       write_side_clock,
	output logic                       read_clock_enable,
	output logic                       read_strobe,
	output logic                       read_side_clock
);
	initial begin
		fifo_wdata         = 8'h00;
		write_clock_enable = 1'b0;
		write_enable       = 1'b0;
		write_side_clock   = 1'b0;
		read_clock_enable  = 1'b0;
		read_strobe        = 1'b0;
		read_side_clock    = 1'b0;
	end

	// -----------------------------------------------------------------
	// write side: data, clock enable, enable and one clock pulse
	// -----------------------------------------------------------------
	task automatic push(input logic [7:0] d);
		@(posedge clk);
		fifo_wdata         <= d;
		write_clock_enable <= 1'b1;
		write_enable       <= 1'b1;
		@(posedge clk);
		write_side_clock   <= 1'b1;
		@(posedge clk);
		write_side_clock   <= 1'b0;
		write_clock_enable <= 1'b0;
		write_enable       <= 1'b0;
		// released data shows the inverse so stale values never look valid
		fifo_wdata         <= ~d;
	endtask : push

	// -----------------------------------------------------------------
	// read side: one read clock pulse, strobe only when en is set
	// -----------------------------------------------------------------
	task automatic pop(input logic en);
		@(posedge clk);
		read_clock_enable <= 1'b1;
		read_strobe       <= en;
		@(posedge clk);
		read_side_clock   <= 1'b1;
		@(posedge clk);
		read_side_clock   <= 1'b0;
		read_clock_enable <= 1'b0;
		read_strobe       <= 1'b0;
	endtask : pop
endmodule : bdf_fabric_model

/* File: bdf_top_tb_top.sv */
// self-checking bench for the block ram / fifo block
// assumes the fabric model drives the fifo ports; the bench drives the rest
`timescale 1ns/1ps

module bdf_top_tb_top;
	import bdf_pkg::*;
	logic       clk, resetn, global_set_reset_n, reg_write, reg_read, ram_a_ce, ram_a_we, ram_b_ce;
	logic       port_a_latch_reset, port_b_latch_reset, fifo_global_reset, read_pointer_reset;
	logic       write_clock_enable, write_enable, write_side_clock, read_clock_enable, read_strobe;
	logic       read_side_clock, full_flag, almost_full_flag, almost_empty_flag, empty_flag;
	logic [2:0] reg_addr;
	logic [3:0] ram_a_addr, ram_b_addr;
	logic [7:0] reg_wdata, reg_rdata, ram_a_wdata, read_data_a, read_data_b, fifo_wdata;
	int         err_count, checks;

	bdf_top DUT (.*);
	bdf_fabric_model FM (.*);

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_read <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
		// read data must drop back to zero after its one cycle
		@(posedge clk);
		#1 chk(reg_rdata, 8'h00);
	endtask : reg_rd

	// one access on port a (b=0) or a read on port b (b=1), then compare its latch
	task automatic ram(input bit b, input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		if (b) begin ram_b_ce <= 1'b1; ram_b_addr <= a; end
		else begin ram_a_ce <= 1'b1; ram_a_we <= w; ram_a_addr <= a; ram_a_wdata <= d; end
		@(posedge clk);
		ram_a_ce <= 1'b0; ram_a_we <= 1'b0; ram_b_ce <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(b ? read_data_b : read_data_a, e);
	endtask : ram

	function automatic logic [7:0] flags();
		return {4'h0, full_flag, almost_full_flag, almost_empty_flag, empty_flag};
	endfunction : flags

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_regs;
		chk(flags(), 8'h03);
		reg_rd(BDF_OFS_CTRL, 8'h00);
		reg_rd(BDF_OFS_FULL, 8'h0F);
		reg_rd(BDF_OFS_AFULL, 8'h0C);
		reg_rd(BDF_OFS_AEMPTY, 8'h02);
		reg_rd(3'h6, 8'h00);
		reg_wr(BDF_OFS_FULL, 8'h00);
		reg_rd(BDF_OFS_FULL, 8'h01);
		reg_wr(BDF_OFS_FULL, 8'h20);
		reg_rd(BDF_OFS_FULL, 8'h0F);
		reg_wr(BDF_OFS_AFULL, 8'hFF);
		reg_rd(BDF_OFS_AFULL, 8'h0E);
		reg_wr(BDF_OFS_CTRL, 8'hE0);
		reg_rd(BDF_OFS_CTRL, 8'h00);
	endtask : t_regs

	task automatic t_ram;
		ram(0, 1, 4'h3, 8'h11, 8'h00);
		ram(0, 0, 4'h3, 8'h00, 8'h11);
		ram(0, 1, 4'h3, 8'h22, 8'h11);
		reg_wr(BDF_OFS_CTRL, 8'h02);
		ram(0, 1, 4'h3, 8'h33, 8'h33);
		reg_wr(BDF_OFS_CTRL, 8'h04);
		ram(0, 1, 4'h3, 8'h44, 8'h33);
		ram(0, 0, 4'h3, 8'h00, 8'h44);
		// reserved write mode code must behave as normal
		reg_wr(BDF_OFS_CTRL, 8'h06);
		ram(0, 1, 4'h5, 8'h55, 8'h44);
		ram(1, 0, 4'h3, 8'h00, 8'h44);
	endtask : t_ram

	task automatic t_latch;
		@(posedge clk) port_a_latch_reset <= 1'b1;
		#1 chk(read_data_a, 8'h44);
		@(posedge clk) port_a_latch_reset <= 1'b0;
		#1 chk(read_data_a, 8'h00);
		chk(read_data_b, 8'h44);
		reg_wr(BDF_OFS_CTRL, 8'h18);
		@(posedge clk) port_b_latch_reset <= 1'b1;
		#1 chk(read_data_b, 8'h00);
		@(posedge clk) port_b_latch_reset <= 1'b0;
		ram(0, 0, 4'h3, 8'h00, 8'h44);
		@(posedge clk) port_a_latch_reset <= 1'b1;
		#1 chk(read_data_a, 8'h00);
		@(posedge clk) port_a_latch_reset <= 1'b0;
		ram(1, 0, 4'h3, 8'h00, 8'h44);
		ram(0, 0, 4'h3, 8'h00, 8'h44);
		@(posedge clk) global_set_reset_n <= 1'b0;
		#1 chk(read_data_a | read_data_b, 8'h00);
		@(posedge clk) global_set_reset_n <= 1'b1;
	endtask : t_latch

	task automatic t_fifo;
		reg_wr(BDF_OFS_CTRL, 8'h01);
		reg_wr(BDF_OFS_FULL, 8'h04);
		reg_wr(BDF_OFS_AFULL, 8'h03);
		reg_wr(BDF_OFS_AEMPTY, 8'h01);
		for (int i = 0; i < 5; i++) FM.push(8'hA0 + 8'(i));
		repeat (2) @(posedge clk);
		#1 chk(flags(), 8'h0F);
		reg_rd(BDF_OFS_COUNT, 8'h04);
		FM.pop(1'b0);
		repeat (2) @(posedge clk);
		#1 chk(flags(), 8'h0C);
		for (int i = 0; i < 2; i++) begin
			FM.pop(1'b1);
			repeat (3) @(posedge clk);
			#1 chk(read_data_b, 8'hA0 + 8'(i));
		end
		@(posedge clk) read_pointer_reset <= 1'b1;
		@(posedge clk) read_pointer_reset <= 1'b0;
		reg_rd(BDF_OFS_COUNT, 8'h04);
		FM.pop(1'b1);
		repeat (3) @(posedge clk);
		#1 chk(read_data_b, 8'hA0);
		@(posedge clk) fifo_global_reset <= 1'b1;
		@(posedge clk) fifo_global_reset <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(flags(), 8'h03);
		reg_rd(BDF_OFS_COUNT, 8'h00);
		FM.pop(1'b1);
		repeat (3) @(posedge clk);
		#1 chk(read_data_b, 8'hA0);
	endtask : t_fifo

	// -----------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		{resetn, reg_write, reg_read, ram_a_ce, ram_a_we, ram_b_ce} = '0;
		{port_a_latch_reset, port_b_latch_reset, fifo_global_reset, read_pointer_reset} = '0;
		global_set_reset_n = 1'b1;
		{reg_addr, ram_a_addr, ram_b_addr, reg_wdata, ram_a_wdata} = '0;
		err_count = 0;
		checks = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		#1;
		t_regs();
		t_ram();
		t_latch();
		t_fifo();
		give_verdict();
	end

	// whole run is under two hundred cycles; ten thousand means a hang
	initial begin
		#(10000 * 100);
		err_count++;
		give_verdict();
	end
endmodule : bdf_top_tb_top
